// >>> rtl/banked_cpu_regs_pkg.sv
package banked_cpu_regs_pkg;

  // Widths
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR20_W  = 20;
  localparam int unsigned STATUS_W  = 11;
  localparam int unsigned WIDE_W    = 32;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned NUM_BANKS = 2;
  localparam int unsigned NUM_DATA  = 4;
  localparam int unsigned NUM_ADDR  = 2;
  localparam int unsigned AV_ADDR_W = 5;
  localparam int unsigned AV_BE_W   = 4;
  localparam int unsigned SWI_NUM_W = 6;

  // Status word bit positions
  localparam int unsigned CARRY_BIT = 0;
  localparam int unsigned DEBUG_BIT = 1;
  localparam int unsigned ZERO_BIT  = 2;
  localparam int unsigned SIGN_BIT  = 3;
  localparam int unsigned BANK_BIT  = 4;
  localparam int unsigned OVFL_BIT  = 5;
  localparam int unsigned IEN_BIT   = 6;
  localparam int unsigned STACK_BIT = 7;
  localparam int unsigned IPL_LSB   = 8;

  // Reset values
  localparam logic [STATUS_W-1:0] STATUS_RESET = 11'h000;
  localparam logic [WORD_W-1:0]   WORD_RESET   = 16'h0000;
  localparam logic [ADDR20_W-1:0] ADDR20_RESET = 20'h00000;
  localparam logic [WIDE_W-1:0]   RD_UNMAPPED  = 32'h0000_0000;

  // Highest software interrupt number that clears the stack bit
  localparam logic [SWI_NUM_W-1:0] SWI_STACK_CLR_MAX = 6'h1f;

  // Bus word offsets
  localparam logic [AV_ADDR_W-1:0] OFS_BANK0  = 5'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_BANK1  = 5'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_VECTOR = 5'h10;
  localparam logic [AV_ADDR_W-1:0] OFS_IP     = 5'h11;
  localparam logic [AV_ADDR_W-1:0] OFS_USP    = 5'h12;
  localparam logic [AV_ADDR_W-1:0] OFS_ISP    = 5'h13;
  localparam logic [AV_ADDR_W-1:0] OFS_SB     = 5'h14;
  localparam logic [AV_ADDR_W-1:0] OFS_STATUS = 5'h15;

  // Slots inside one bank window
  localparam int unsigned SLOT_W     = 3;
  localparam int unsigned BANK_A_BIT = 3;
  localparam logic [SLOT_W-1:0] SLOT_DATA0 = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_DATA3 = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_ADDR0 = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_ADDR1 = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_FRAME = 3'h6;

  // Register selector of the core datapath
  typedef enum logic [3:0] {
    REG_DATA0, REG_DATA1, REG_DATA2, REG_DATA3, REG_ADDR0, REG_ADDR1,
    REG_FRAME, REG_VECTOR, REG_IP, REG_SP, REG_USP, REG_ISP, REG_SB,
    REG_STATUS
  } reg_id_e;

  // Access width
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_e;

  // Core write request
  typedef struct packed {
    logic                en;
    reg_id_e             sel;
    size_e               size;
    logic                upper;
    logic [WIDE_W-1:0]   data;
  } core_wr_s;

  // Core read request
  typedef struct packed {
    reg_id_e sel;
    size_e   size;
    logic    upper;
  } core_rd_s;

  // Always-visible pointers for the address path
  typedef struct packed {
    logic [ADDR20_W-1:0] ip;
    logic [ADDR20_W-1:0] vectorBase;
    logic [WORD_W-1:0]   activeSp;
    logic [WORD_W-1:0]   frameBase;
    logic [WORD_W-1:0]   staticBase;
    logic [WIDE_W-1:0]   wideAddr;
    logic [STATUS_W-1:0] status;
  } core_view_s;

endpackage

// >>> rtl/banked_cpu_register_file.sv
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module banked_cpu_register_file (
  // Clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  // Avalon-MM slave
  input  wire logic [banked_cpu_regs_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic [31:0]                             avs_readdata,
  output logic                                    avs_waitrequest,
  // Core datapath ports
  input  wire banked_cpu_regs_pkg::core_wr_s      coreWr,
  input  wire banked_cpu_regs_pkg::core_rd_s      coreRd,
  output logic [31:0]                             coreRdData,
  // Interrupt entry events
  input  wire logic                               hwIntAccept,
  input  wire logic                               swIntExec,
  input  wire logic [banked_cpu_regs_pkg::SWI_NUM_W-1:0] swIntNum,
  // Pointer view
  output banked_cpu_regs_pkg::core_view_s         coreView
);

  localparam int unsigned W  = banked_cpu_regs_pkg::WORD_W;
  localparam int unsigned W20 = banked_cpu_regs_pkg::ADDR20_W;
  localparam int unsigned NB = banked_cpu_regs_pkg::NUM_BANKS;

  // Banked storage: data, address, frame base per bank
  // Seven per bank plus six shared make the visible set
  logic [W-1:0] dataReg  [NB][banked_cpu_regs_pkg::NUM_DATA];
  logic [W-1:0] addrReg  [NB][banked_cpu_regs_pkg::NUM_ADDR];
  logic [W-1:0] frameReg [NB];
  // Shared storage
  logic [W20-1:0] vectorBase;
  logic [W20-1:0] ipReg;
  logic [W-1:0]   userSp;
  logic [W-1:0]   intSp;
  logic [W-1:0]   staticBase;
  logic [banked_cpu_regs_pkg::STATUS_W-1:0] status;

  // Selections taken from the status word, plus bus and decode helpers
  logic           activeBank;   // Bank in use
  logic           userStack;    // User pointer in use
  logic [W-1:0]   activeSp;     // Current stack pointer
  logic           busWr;        // Bus write commits this edge
  logic           busReq;       // Any bus request present
  logic [31:0]    busRdValue;   // Decoded bus read value
  logic [31:0]    busWrValue;   // Lane-merged bus write value
  logic [31:0]    busOld;       // Current content of target
  logic [31:0]    coreRdValue;  // Decoded core read value
  logic           swiClears;    // Soft int in clearing range

  assign activeBank = status[banked_cpu_regs_pkg::BANK_BIT];
  assign userStack  = status[banked_cpu_regs_pkg::STACK_BIT];
  assign activeSp   = userStack ? userSp : intSp;
  assign busReq     = avs_read | avs_write;
  assign busWr      = avs_write & ~avs_waitrequest;
  assign swiClears  = swIntExec &&
                      (swIntNum <= banked_cpu_regs_pkg::SWI_STACK_CLR_MAX);

  // Replace only enabled byte lanes
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < banked_cpu_regs_pkg::AV_BE_W; i++) begin
      if (be[i]) begin
        m[i*banked_cpu_regs_pkg::BYTE_W +: banked_cpu_regs_pkg::BYTE_W] =
          wd[i*banked_cpu_regs_pkg::BYTE_W +: banked_cpu_regs_pkg::BYTE_W];
      end
    end
    return m;
  endfunction

  // Byte or word update of a 16-bit register
  function automatic logic [W-1:0] put16(input logic [W-1:0] old,
                                         input logic [31:0]  wd,
                                         input logic         byteOp,
                                         input logic         upper);
    logic [W-1:0] v;
    v = wd[W-1:0];
    if (byteOp) begin
      if (upper) begin
        v = {wd[7:0], old[7:0]};
      end else begin
        v = {old[15:8], wd[7:0]};
      end
    end
    return v;
  endfunction

  // Bus address decode for reads and merge source
  always_comb begin
    busRdValue = banked_cpu_regs_pkg::RD_UNMAPPED;
    if (avs_address < banked_cpu_regs_pkg::OFS_VECTOR &&
        avs_address[2:0] <= banked_cpu_regs_pkg::SLOT_FRAME) begin
      // Either bank is visible, whatever the bank bit says
      if (avs_address[2:0] <= banked_cpu_regs_pkg::SLOT_DATA3) begin
        busRdValue = 32'(dataReg[avs_address[3]][avs_address[1:0]]);
      end else if (avs_address[2:0] == banked_cpu_regs_pkg::SLOT_FRAME) begin
        busRdValue = 32'(frameReg[avs_address[3]]);
      end else begin
        busRdValue = 32'(addrReg[avs_address[3]][avs_address[0]]);
      end
    end else if (avs_address == banked_cpu_regs_pkg::OFS_VECTOR) begin
      busRdValue = 32'(vectorBase);
    end else if (avs_address == banked_cpu_regs_pkg::OFS_IP) begin
      busRdValue = 32'(ipReg);
    end else if (avs_address == banked_cpu_regs_pkg::OFS_USP) begin
      busRdValue = 32'(userSp);
    end else if (avs_address == banked_cpu_regs_pkg::OFS_ISP) begin
      busRdValue = 32'(intSp);
    end else if (avs_address == banked_cpu_regs_pkg::OFS_SB) begin
      busRdValue = 32'(staticBase);
    end else if (avs_address == banked_cpu_regs_pkg::OFS_STATUS) begin
      busRdValue = 32'(status);
    end
  end

  // Unwritten lanes keep the old content
  assign busOld     = busRdValue;
  assign busWrValue = laneMerge(busOld, avs_writedata, avs_byteenable);

  // Core read decode, always through the active bank
  always_comb begin
    coreRdValue = banked_cpu_regs_pkg::RD_UNMAPPED;
    case (coreRd.sel)
      banked_cpu_regs_pkg::REG_DATA0,
      banked_cpu_regs_pkg::REG_DATA1: begin
        if (coreRd.size == banked_cpu_regs_pkg::SIZE_LONG) begin
          // Upper half from the register two above
          coreRdValue = {dataReg[activeBank][coreRd.sel[1:0] + 2'h2],
                         dataReg[activeBank][coreRd.sel[1:0]]};
        end else if (coreRd.size == banked_cpu_regs_pkg::SIZE_BYTE) begin
          coreRdValue = coreRd.upper ?
            32'(dataReg[activeBank][coreRd.sel[1:0]][15:8]) :
            32'(dataReg[activeBank][coreRd.sel[1:0]][7:0]);
        end else begin
          coreRdValue = 32'(dataReg[activeBank][coreRd.sel[1:0]]);
        end
      end
      banked_cpu_regs_pkg::REG_DATA2,
      banked_cpu_regs_pkg::REG_DATA3: begin
        coreRdValue = 32'(dataReg[activeBank][coreRd.sel[1:0]]);
      end
      banked_cpu_regs_pkg::REG_ADDR0: begin
        if (coreRd.size == banked_cpu_regs_pkg::SIZE_LONG) begin
          coreRdValue = {addrReg[activeBank][1],
                         addrReg[activeBank][0]};
        end else begin
          coreRdValue = 32'(addrReg[activeBank][0]);
        end
      end
      banked_cpu_regs_pkg::REG_ADDR1: begin
        coreRdValue = 32'(addrReg[activeBank][1]);
      end
      banked_cpu_regs_pkg::REG_FRAME: begin
        coreRdValue = 32'(frameReg[activeBank]);
      end
      banked_cpu_regs_pkg::REG_VECTOR: coreRdValue = 32'(vectorBase);
      banked_cpu_regs_pkg::REG_IP:     coreRdValue = 32'(ipReg);
      banked_cpu_regs_pkg::REG_SP:     coreRdValue = 32'(activeSp);
      banked_cpu_regs_pkg::REG_USP:    coreRdValue = 32'(userSp);
      banked_cpu_regs_pkg::REG_ISP:    coreRdValue = 32'(intSp);
      banked_cpu_regs_pkg::REG_SB:     coreRdValue = 32'(staticBase);
      banked_cpu_regs_pkg::REG_STATUS: coreRdValue = 32'(status);
      default:                         coreRdValue = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data captured with the wait drop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= banked_cpu_regs_pkg::RD_UNMAPPED;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= busRdValue;
    end
  end

  // Banked registers; core write lands last so it wins a tie
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int b = 0; b < NB; b++) begin
        for (int r = 0; r < banked_cpu_regs_pkg::NUM_DATA; r++) begin
          dataReg[b][r] <= banked_cpu_regs_pkg::WORD_RESET;
        end
        for (int r = 0; r < banked_cpu_regs_pkg::NUM_ADDR; r++) begin
          addrReg[b][r] <= banked_cpu_regs_pkg::WORD_RESET;
        end
        frameReg[b] <= banked_cpu_regs_pkg::WORD_RESET;
      end
    end else begin
      // Software reaches both banks directly
      if (busWr && avs_address < banked_cpu_regs_pkg::OFS_VECTOR) begin
        if (avs_address[2:0] <= banked_cpu_regs_pkg::SLOT_DATA3) begin
          dataReg[avs_address[3]][avs_address[1:0]] <= busWrValue[W-1:0];
        end else if (avs_address[2:0] == banked_cpu_regs_pkg::SLOT_ADDR0 ||
                     avs_address[2:0] == banked_cpu_regs_pkg::SLOT_ADDR1) begin
          addrReg[avs_address[3]][avs_address[0]] <= busWrValue[W-1:0];
        end else if (avs_address[2:0] == banked_cpu_regs_pkg::SLOT_FRAME) begin
          frameReg[avs_address[3]] <= busWrValue[W-1:0];
        end
      end
      // Core only touches the bank chosen by the status word
      if (coreWr.en) begin
        case (coreWr.sel)
          banked_cpu_regs_pkg::REG_DATA0,
          banked_cpu_regs_pkg::REG_DATA1: begin
            dataReg[activeBank][coreWr.sel[1:0]] <=
              put16(dataReg[activeBank][coreWr.sel[1:0]], coreWr.data,
                    coreWr.size == banked_cpu_regs_pkg::SIZE_BYTE,
                    coreWr.upper);
            if (coreWr.size == banked_cpu_regs_pkg::SIZE_LONG) begin
              dataReg[activeBank][coreWr.sel[1:0] + 2'h2] <=
                coreWr.data[31:16];
            end
          end
          banked_cpu_regs_pkg::REG_DATA2,
          banked_cpu_regs_pkg::REG_DATA3: begin
            dataReg[activeBank][coreWr.sel[1:0]] <= coreWr.data[W-1:0];
          end
          banked_cpu_regs_pkg::REG_ADDR0: begin
            addrReg[activeBank][0] <= coreWr.data[W-1:0];
            if (coreWr.size == banked_cpu_regs_pkg::SIZE_LONG) begin
              addrReg[activeBank][1] <= coreWr.data[31:16];
            end
          end
          banked_cpu_regs_pkg::REG_ADDR1: begin
            addrReg[activeBank][1] <= coreWr.data[W-1:0];
          end
          banked_cpu_regs_pkg::REG_FRAME: begin
            frameReg[activeBank] <= coreWr.data[W-1:0];
          end
          default: begin
            // Shared registers handled below
          end
        endcase
      end
    end
  end

  // Shared registers; never copied on a bank switch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vectorBase <= banked_cpu_regs_pkg::ADDR20_RESET;
      ipReg      <= banked_cpu_regs_pkg::ADDR20_RESET;
      userSp     <= banked_cpu_regs_pkg::WORD_RESET;
      intSp      <= banked_cpu_regs_pkg::WORD_RESET;
      staticBase <= banked_cpu_regs_pkg::WORD_RESET;
    end else begin
      if (busWr) begin
        if (avs_address == banked_cpu_regs_pkg::OFS_VECTOR) begin
          vectorBase <= busWrValue[W20-1:0];
        end else if (avs_address == banked_cpu_regs_pkg::OFS_IP) begin
          ipReg <= busWrValue[W20-1:0];
        end else if (avs_address == banked_cpu_regs_pkg::OFS_USP) begin
          userSp <= busWrValue[W-1:0];
        end else if (avs_address == banked_cpu_regs_pkg::OFS_ISP) begin
          intSp <= busWrValue[W-1:0];
        end else if (avs_address == banked_cpu_regs_pkg::OFS_SB) begin
          staticBase <= busWrValue[W-1:0];
        end
      end
      if (coreWr.en) begin
        case (coreWr.sel)
          banked_cpu_regs_pkg::REG_VECTOR: vectorBase <= coreWr.data[W20-1:0];
          banked_cpu_regs_pkg::REG_IP:     ipReg <= coreWr.data[W20-1:0];
          banked_cpu_regs_pkg::REG_SP: begin
            // Generic pointer writes go to whichever is active
            if (userStack) begin
              userSp <= coreWr.data[W-1:0];
            end else begin
              intSp <= coreWr.data[W-1:0];
            end
          end
          banked_cpu_regs_pkg::REG_USP:    userSp <= coreWr.data[W-1:0];
          banked_cpu_regs_pkg::REG_ISP:    intSp <= coreWr.data[W-1:0];
          banked_cpu_regs_pkg::REG_SB:  staticBase <= coreWr.data[W-1:0];
          default: begin
            // Banked registers handled above
          end
        endcase
      end
    end
  end

  // Status word; stack bit clears on hardware or in-range soft entry, and the enable clear on hardware entry, override any write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= banked_cpu_regs_pkg::STATUS_RESET;
    end else begin
      if (busWr && avs_address == banked_cpu_regs_pkg::OFS_STATUS) begin
        status <= busWrValue[banked_cpu_regs_pkg::STATUS_W-1:0];
      end
      if (coreWr.en && coreWr.sel == banked_cpu_regs_pkg::REG_STATUS) begin
        status <= coreWr.data[banked_cpu_regs_pkg::STATUS_W-1:0];
      end
      if (hwIntAccept || swiClears) begin
        status[banked_cpu_regs_pkg::STACK_BIT] <= 1'b0;
      end
      // Maskable entry also closes the interrupt gate
      if (hwIntAccept) begin
        status[banked_cpu_regs_pkg::IEN_BIT] <= 1'b0;
      end
    end
  end

  // Registered core read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coreRdData <= banked_cpu_regs_pkg::RD_UNMAPPED;
    end else begin
      coreRdData <= coreRdValue;
    end
  end

  // Registered pointer view; lags storage by one edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coreView <= '0;
    end else begin
      coreView.ip         <= ipReg;
      coreView.vectorBase <= vectorBase;
      coreView.activeSp   <= activeSp;
      coreView.frameBase  <= frameReg[activeBank];
      coreView.staticBase <= staticBase;
      coreView.wideAddr   <= {addrReg[activeBank][1],
                              addrReg[activeBank][0]};
      coreView.status     <= status;
    end
  end

endmodule
`default_nettype wire

// >>> tb/banked_cpu_register_file_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module banked_cpu_register_file_asserts (
  // Clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst,
  // Register bus
  input wire logic [4:0]                     avs_address,
  input wire logic                           avs_read,
  input wire logic                           avs_write,
  input wire logic [31:0]                    avs_readdata,
  input wire logic                           avs_waitrequest,
  // Core side
  input wire banked_cpu_regs_pkg::core_wr_s  coreWr,
  input wire logic                           hwIntAccept,
  input wire logic                           swIntExec,
  input wire logic [5:0]                     swIntNum,
  input wire banked_cpu_regs_pkg::core_view_s coreView
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Nothing else touches the register in the following cycle
  sequence quiet;
    ##1 !coreWr.en && !avs_write;
  endsequence
  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");
  a_wait_back_high: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait_high: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_unmapped_reads_zero: assert property (
    avs_read && avs_waitrequest &&
    (avs_address > 5'h15 || avs_address[2:0] == 3'h7)
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_swi_clears_stack: assert property (
    swIntExec && swIntNum <= 6'h1f |=> ##1 !coreView.status[7])
    else $error("soft interrupt kept stack bit");
  a_hw_clears_bits: assert property (
    hwIntAccept |=> ##1 !coreView.status[7] && !coreView.status[6])
    else $error("hw interrupt kept stack or enable bit");
  a_wide_addr_pair: assert property (
    coreWr.en && coreWr.sel == banked_cpu_regs_pkg::REG_ADDR0 &&
    coreWr.size == banked_cpu_regs_pkg::SIZE_LONG ##0 quiet
    |=> coreView.wideAddr == $past(coreWr.data, 2))
    else $error("wide address pair wrong");
  a_frame_word_view: assert property (
    coreWr.en && coreWr.sel == banked_cpu_regs_pkg::REG_FRAME ##0 quiet
    |=> coreView.frameBase == $past(coreWr.data[15:0], 2))
    else $error("frame base view wrong");
  // Main scenarios seen
  c_bus_read: cover property (avs_read && !avs_waitrequest);
  c_swi: cover property (swIntExec && swIntNum == 6'h1f);
  c_hw: cover property (hwIntAccept);
endmodule
bind banked_cpu_register_file banked_cpu_register_file_asserts u_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .coreWr(coreWr), .hwIntAccept(hwIntAccept), .swIntExec(swIntExec),
  .swIntNum(swIntNum), .coreView(coreView));
`default_nettype wire

// >>> tb/core_datapath_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_datapath_model (
  // Clock
  input wire logic                            sys_clk,
  // Register file ports
  output banked_cpu_regs_pkg::core_wr_s       coreWr,
  output banked_cpu_regs_pkg::core_rd_s       coreRd,
  input wire logic [31:0]                     coreRdData,
  // Interrupt entry events
  output logic                                hwIntAccept,
  output logic                                swIntExec,
  output logic [5:0]                          swIntNum
);
  // Quiet start
  initial begin
    coreWr = '0;
    coreRd = '0;
    hwIntAccept = 1'b0;
    swIntExec = 1'b0;
    swIntNum = 6'h00;
  end
  // One write, taken at the next edge; data scrambled once idle
  task automatic wr(input logic [3:0] s, input logic [1:0] z,
                    input logic u, input logic [31:0] d);
    coreWr <= '{1'b1, banked_cpu_regs_pkg::reg_id_e'(s),
                banked_cpu_regs_pkg::size_e'(z), u, d};
    @(posedge sys_clk);
    coreWr.en <= 1'b0;
    coreWr.data <= ~d;
  endtask
  // One read; result sampled mid-cycle, clear of the edge
  task automatic rd(input logic [3:0] s, input logic [1:0] z,
                    input logic u, output logic [31:0] q);
    coreRd <= '{banked_cpu_regs_pkg::reg_id_e'(s),
                banked_cpu_regs_pkg::size_e'(z), u};
    @(posedge sys_clk);
    @(negedge sys_clk) q = coreRdData;
    @(posedge sys_clk);
  endtask
  // One-cycle interrupt entry pulse
  task automatic irq(input logic hw, input logic sw, input logic [5:0] n);
    hwIntAccept <= hw;
    swIntExec <= sw;
    swIntNum <= n;
    @(posedge sys_clk);
    hwIntAccept <= 1'b0;
    swIntExec <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_banked_cpu_register_file.sv
`timescale 1ns/100ps
`default_nettype none
module tb_banked_cpu_register_file;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] coreRdData;
  logic        hwIntAccept;
  logic        swIntExec;
  logic [5:0]  swIntNum;
  logic [31:0] q;
  int          errors = 0;
  int          checks = 0;
  banked_cpu_regs_pkg::core_wr_s   coreWr;
  banked_cpu_regs_pkg::core_rd_s   coreRd;
  banked_cpu_regs_pkg::core_view_s coreView;
  // Write on core port, then read back: sel, size, upper, data
  typedef struct {
    logic [3:0] ws; logic [1:0] wz; logic wu; logic [31:0] wd;
    logic [3:0] rs; logic [1:0] rz; logic ru; logic [31:0] ex;
  } row_s;
  row_s rows [13] = '{
    '{4'h0, 2'h1, 1'b0, 32'h1234, 4'h0, 2'h1, 1'b0, 32'h1234},
    '{4'h0, 2'h0, 1'b1, 32'h00ab, 4'h0, 2'h1, 1'b0, 32'hab34},
    '{4'h1, 2'h0, 1'b0, 32'h00cd, 4'h1, 2'h0, 1'b0, 32'h00cd},
    '{4'h0, 2'h2, 1'b0, 32'h89abcdef, 4'h2, 2'h1, 1'b0, 32'h89ab},
    '{4'h1, 2'h2, 1'b0, 32'h1234567, 4'h1, 2'h2, 1'b0, 32'h1234567},
    '{4'h4, 2'h2, 1'b0, 32'hfedcba98, 4'h5, 2'h1, 1'b0, 32'hfedc},
    '{4'h6, 2'h1, 1'b0, 32'h2468, 4'h6, 2'h1, 1'b0, 32'h2468},
    '{4'hd, 2'h1, 1'b0, 32'h0010, 4'h0, 2'h1, 1'b0, 32'h0},
    '{4'h0, 2'h1, 1'b0, 32'h5555, 4'h6, 2'h1, 1'b0, 32'h0},
    '{4'hd, 2'h1, 1'b0, 32'h0, 4'h0, 2'h2, 1'b0, 32'h89abcdef},
    '{4'ha, 2'h1, 1'b0, 32'h1111, 4'h9, 2'h1, 1'b0, 32'h0},
    '{4'hd, 2'h1, 1'b0, 32'h0080, 4'h9, 2'h1, 1'b0, 32'h1111},
    '{4'hb, 2'h1, 1'b0, 32'h2222, 4'hb, 2'h1, 1'b0, 32'h2222}};
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  banked_cpu_register_file dut_u (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .coreWr(coreWr), .coreRd(coreRd), .coreRdData(coreRdData),
    .hwIntAccept(hwIntAccept), .swIntExec(swIntExec),
    .swIntNum(swIntNum), .coreView(coreView));
  core_datapath_model core_u (
    .sys_clk(sys_clk), .coreWr(coreWr), .coreRd(coreRd),
    .coreRdData(coreRdData), .hwIntAccept(hwIntAccept),
    .swIntExec(swIntExec), .swIntNum(swIntNum));
  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge so the next call never re-raises in this step
    @(posedge sys_clk);
    if (n >= 20) begin
      errors++;
      results();
    end
  endtask
  // Bus read compared with expectation
  task automatic bchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk("bus read", q, e);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("idle wait", {31'h0, avs_waitrequest}, 32'h1);
    chk("status view", {21'h0, coreView.status}, 32'h0);
    @(posedge sys_clk);
    bchk(5'h15, 32'h0);
    // Table of core write and read-back pairs
    foreach (rows[i]) begin
      core_u.wr(rows[i].ws, rows[i].wz, rows[i].wu, rows[i].wd);
      core_u.rd(rows[i].rs, rows[i].rz, rows[i].ru, q);
      chk("core read", q, rows[i].ex);
    end
    bchk(5'h08, 32'h5555);
    bchk(5'h00, 32'hcdef);
    // Widths clip what the bus writes
    bus(1'b1, 5'h10, 32'hffffffff, 4'hf);
    bchk(5'h10, 32'hfffff);
    bus(1'b1, 5'h11, 32'hffffffff, 4'hf);
    bchk(5'h11, 32'hfffff);
    bus(1'b1, 5'h14, 32'hffffffff, 4'hf);
    bus(1'b1, 5'h14, 32'h0, 4'h1);
    bchk(5'h14, 32'hff00);
    bus(1'b1, 5'h15, 32'hffffffff, 4'hf);
    bchk(5'h15, 32'h7ff);
    // Interrupt entries against a full status word
    core_u.irq(1'b1, 1'b0, 6'h00);
    bchk(5'h15, 32'h73f);
    bus(1'b1, 5'h15, 32'h7ff, 4'hf);
    core_u.irq(1'b0, 1'b1, 6'h20);
    bchk(5'h15, 32'h7ff);
    core_u.irq(1'b0, 1'b1, 6'h1f);
    bchk(5'h15, 32'h77f);
    // Unmapped words read zero, writes dropped
    bus(1'b1, 5'h07, 32'hffffffff, 4'hf);
    bchk(5'h07, 32'h0);
    bchk(5'h1f, 32'h0);
    // Pointer view against the values written above
    @(negedge sys_clk);
    chk("view ip", {12'h0, coreView.ip}, 32'hfffff);
    chk("view vector", {12'h0, coreView.vectorBase}, 32'hfffff);
    chk("view sp", {16'h0, coreView.activeSp}, 32'h2222);
    chk("view sb", {16'h0, coreView.staticBase}, 32'hff00);
    results();
  end
endmodule
`default_nettype wire
